// file: design/lblp_primitives.sv
// Ladder bit-logic primitives evaluated once per scan strobe.
//
// Overview of operation
// - Each output coil drives its output bit to the running logic result that reaches it.
// - Each inverter replaces the running logic result with its complement for what follows.
// - Each midline connector saves the running logic result into its own store and passes it on.
// - The move copies its source unchanged to its destination at 8, 16 or 32 bits, same width both sides.
// - With enable driven, the move destination is a register that updates only while enable is true.
// - The widening primitive sign-extends a signed 16-bit input to the equal signed 32-bit value.
// - The reset-priority latch sets on set alone and clears on reset alone.
// - The reset-priority latch clears when set and reset are both 1.
// - The set-priority latch clears on reset alone and sets on set alone.
// - The set-priority latch sets when set and reset are both 1.
// - Each latch instance owns its own storage element, and the program gives each a unique label.
// - The rising-edge detector outputs 1 for one evaluation only when its memory holds 0 and input is 1.
// - After each evaluation the rising-edge detector writes its input into its edge memory bit.
`timescale 1ns/1ps
`default_nettype none

module lblp_primitives (
  input  wire logic                                  core_clk,
  input  wire logic                                  reset_n,
  input  wire logic                                  scan_en,
  input  wire logic [lblp_pkg::COIL_COUNT-1:0]       coil_result_in,
  output logic      [lblp_pkg::COIL_COUNT-1:0]       coil_out_q,
  input  wire logic [lblp_pkg::INV_COUNT-1:0]        inv_result_in,
  output logic      [lblp_pkg::INV_COUNT-1:0]        inv_result_q,
  input  wire logic [lblp_pkg::CONN_COUNT-1:0]       conn_result_in,
  output logic      [lblp_pkg::CONN_COUNT-1:0]       conn_store_q,
  output logic      [lblp_pkg::CONN_COUNT-1:0]       conn_pass_q,
  input  wire logic                                  move_en,
  input  wire lblp_pkg::lblp_move_width_type         move_width,
  input  wire logic [lblp_pkg::MOVE_WIDTH-1:0]       move_src,
  output logic      [lblp_pkg::MOVE_WIDTH-1:0]       move_dst_q,
  output logic                                       move_enable_passthrough_out_q,
  input  wire logic                                  widen_en,
  input  wire logic [lblp_pkg::WIDEN_IN_W-1:0]       widen_in,
  output logic      [lblp_pkg::WIDEN_OUT_W-1:0]      widen_out_q,
  output logic                                       widen_enable_passthrough_out_q,
  input  wire logic [lblp_pkg::LATCH_COUNT-1:0]      rpl_set,
  input  wire logic [lblp_pkg::LATCH_COUNT-1:0]      rpl_reset,
  output logic      [lblp_pkg::LATCH_COUNT-1:0]      reset_priority_latch_q,
  input  wire logic [lblp_pkg::LATCH_COUNT-1:0]      spl_set,
  input  wire logic [lblp_pkg::LATCH_COUNT-1:0]      spl_reset,
  output logic      [lblp_pkg::LATCH_COUNT-1:0]      set_priority_latch_q,
  input  wire logic [lblp_pkg::EDGE_COUNT-1:0]       edge_result_in,
  output logic      [lblp_pkg::EDGE_COUNT-1:0]       edge_pulse_q,
  output logic      [lblp_pkg::EDGE_COUNT-1:0]       edge_memory_q
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Next state of one latch; prio_set picks which input wins a tie
  function automatic logic latch_next(
    input logic prio_set,
    input logic set_in,
    input logic reset_in,
    input logic state
  );
    logic next_val;
    next_val = state;                          // Hold when both inputs low
    if (set_in && reset_in)
    begin
      next_val = prio_set;                     // Tie broken by priority
    end
    else if (set_in)
    begin
      next_val = 1'h1;                         // Set alone
    end
    else if (reset_in)
    begin
      next_val = 1'h0;                         // Reset alone
    end
    return next_val;
  endfunction : latch_next

  // Masks a move source to the chosen operand width
  function automatic logic [lblp_pkg::MOVE_WIDTH-1:0] move_mask(
    input lblp_pkg::lblp_move_width_type width_sel,
    input logic [lblp_pkg::MOVE_WIDTH-1:0] src
  );
    logic [lblp_pkg::MOVE_WIDTH-1:0] result;
    result = src;
    unique case (width_sel)
      lblp_pkg::LBLP_MOVE_W8:
      begin
        result = {{(lblp_pkg::MOVE_WIDTH-lblp_pkg::BYTE_W){1'b0}}, src[lblp_pkg::BYTE_W-1:0]};
      end
      lblp_pkg::LBLP_MOVE_W16:
      begin
        result = {{(lblp_pkg::MOVE_WIDTH-lblp_pkg::HALF_W){1'b0}}, src[lblp_pkg::HALF_W-1:0]};
      end
      lblp_pkg::LBLP_MOVE_W32:
      begin
        result = src;
      end
      default:
      begin
        result = src;                          // Unused code falls back to full width
      end
    endcase
    return result;
  endfunction : move_mask

  // ----------------------------------------------------------------
  // Bit primitives: coil, inverter, midline connector
  // ----------------------------------------------------------------

  // Coils follow the rung result once per scan
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      coil_out_q <= lblp_pkg::COIL_RESET;
    end
    else if (scan_en)
    begin
      coil_out_q <= coil_result_in;
    end
  end

  // Inverters carry no operand, only the negated rung result
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      inv_result_q <= lblp_pkg::INV_RESET;
    end
    else if (scan_en)
    begin
      inv_result_q <= ~inv_result_in;
    end
  end

  // Connectors save the branch result and pass it along untouched
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      conn_store_q <= lblp_pkg::CONN_RESET;
      conn_pass_q  <= lblp_pkg::CONN_RESET;
    end
    else if (scan_en)
    begin
      conn_store_q <= conn_result_in;
      conn_pass_q  <= conn_result_in;
    end
  end

  // ----------------------------------------------------------------
  // Retentive word primitives: move and integer widening
  // ----------------------------------------------------------------

  // Destination holds between enabled scans; upper bits zero below 32
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      move_dst_q <= lblp_pkg::MOVE_RESET;
    end
    else if (scan_en && move_en)
    begin
      move_dst_q <= move_mask(move_width, move_src);
    end
  end

  // Enable pass-through mirrors the enable at each scan
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      move_enable_passthrough_out_q  <= 1'h0;
      widen_enable_passthrough_out_q <= 1'h0;
    end
    else if (scan_en)
    begin
      move_enable_passthrough_out_q  <= move_en;
      widen_enable_passthrough_out_q <= widen_en;
    end
  end

  // Sign extension keeps negative values negative
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      widen_out_q <= lblp_pkg::WIDEN_RESET;
    end
    else if (scan_en && widen_en)
    begin
      widen_out_q <= {{(lblp_pkg::WIDEN_OUT_W-lblp_pkg::WIDEN_IN_W){widen_in[lblp_pkg::HALF_SIGN]}},
                      widen_in};
    end
  end

  // ----------------------------------------------------------------
  // Latches: one storage bit per labelled instance
  // ----------------------------------------------------------------

  // Separate bits per index, so no two instances can alias
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      reset_priority_latch_q <= lblp_pkg::LATCH_RESET;
      set_priority_latch_q   <= lblp_pkg::LATCH_RESET;
    end
    else if (scan_en)
    begin
      for (int i = 0; i < lblp_pkg::LATCH_COUNT; i++)
      begin
        reset_priority_latch_q[i] <= latch_next(1'h0, rpl_set[i], rpl_reset[i],
                                                reset_priority_latch_q[i]);
        set_priority_latch_q[i]   <= latch_next(1'h1, spl_set[i], spl_reset[i],
                                                set_priority_latch_q[i]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Rising-edge detectors on the running result
  // ----------------------------------------------------------------

  // Pulse lasts one scan; memory is compared before it is overwritten
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      edge_pulse_q  <= lblp_pkg::EDGE_RESET;
      edge_memory_q <= lblp_pkg::EDGE_RESET;
    end
    else if (scan_en)
    begin
      edge_pulse_q  <= edge_result_in & ~edge_memory_q;
      edge_memory_q <= edge_result_in;
    end
  end

endmodule : lblp_primitives

`default_nettype wire

// file: design/lblp_pkg.sv
// Package holding the constants and types shared by the ladder primitive block.
package lblp_pkg;

  // ----------------------------------------------------------------
  // Instance counts of each primitive kind
  // ----------------------------------------------------------------
  localparam int unsigned COIL_COUNT  = 8;
  localparam int unsigned INV_COUNT   = 8;
  localparam int unsigned CONN_COUNT  = 8;
  localparam int unsigned LATCH_COUNT = 4;
  localparam int unsigned EDGE_COUNT  = 4;

  // ----------------------------------------------------------------
  // Data widths
  // ----------------------------------------------------------------
  localparam int unsigned MOVE_WIDTH   = 32;
  localparam int unsigned WIDEN_IN_W   = 16;
  localparam int unsigned WIDEN_OUT_W  = 32;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned HALF_W       = 16;
  localparam int unsigned HALF_SIGN    = 15;

  // ----------------------------------------------------------------
  // Move operand width selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LBLP_MOVE_W8  = 2'h0,
    LBLP_MOVE_W16 = 2'h1,
    LBLP_MOVE_W32 = 2'h3
  } lblp_move_width_type;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [COIL_COUNT-1:0]  COIL_RESET  = 8'h00;
  localparam logic [INV_COUNT-1:0]   INV_RESET   = 8'h00;
  localparam logic [CONN_COUNT-1:0]  CONN_RESET  = 8'h00;
  localparam logic [LATCH_COUNT-1:0] LATCH_RESET = 4'h0;
  localparam logic [EDGE_COUNT-1:0]  EDGE_RESET  = 4'h0;
  localparam logic [MOVE_WIDTH-1:0]  MOVE_RESET  = 32'h0000_0000;
  localparam logic [WIDEN_OUT_W-1:0] WIDEN_RESET = 32'h0000_0000;

endpackage : lblp_pkg

// file: verif/lblp_chk.sv
// Concurrent checks on the ports of the ladder primitive block.
`timescale 1ns/1ps
`default_nettype none

module lblp_chk (
  input wire logic                        core_clk, reset_n, scan_en, move_en, widen_en,
  input wire logic                        move_enable_passthrough_out_q, widen_enable_passthrough_out_q,
  input wire logic [7:0]                  coil_result_in, coil_out_q, inv_result_in, inv_result_q,
  input wire logic [7:0]                  conn_result_in, conn_store_q, conn_pass_q,
  input wire lblp_pkg::lblp_move_width_type move_width,
  input wire logic [31:0]                 move_src, move_dst_q, widen_out_q,
  input wire logic [15:0]                 widen_in,
  input wire logic [3:0]                  rpl_set, rpl_reset, reset_priority_latch_q,
  input wire logic [3:0]                  spl_set, spl_reset, set_priority_latch_q,
  input wire logic [3:0]                  edge_result_in, edge_pulse_q, edge_memory_q
);
  // ----------------------------------------------------------------
  // Scan relations, each seen one cycle after the taken edge
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Rise on lane 0, then the same level scanned again
  sequence s_scan; scan_en; endsequence
  sequence s_rise; scan_en && edge_result_in[0] && !edge_memory_q[0]; endsequence
  sequence s_again; scan_en && edge_result_in[0]; endsequence

  a_coil_follow:
    assert property (s_scan |=> coil_out_q == $past(coil_result_in)) else $error("coil mismatch");
  a_inv_flip:
    assert property (s_scan |=> inv_result_q == ~$past(inv_result_in)) else $error("inverter mismatch");
  a_conn_save:
    assert property (s_scan |=> conn_store_q == $past(conn_result_in) && conn_pass_q == conn_store_q)
      else $error("connector mismatch");
  // Plain expressions here: a named sequence may not be an operand of a logical and
  a_move_copy:
    assert property (scan_en && move_en && move_width == lblp_pkg::LBLP_MOVE_W32 |=> move_dst_q == $past(move_src))
      else $error("move copy mismatch");
  a_move_hold:
    assert property (!(scan_en && move_en) |=> $stable(move_dst_q)) else $error("move changed while idle");
  a_widen_sign:
    assert property (scan_en && widen_en |=> widen_out_q == {{16{$past(widen_in[15])}}, $past(widen_in)})
      else $error("widen mismatch");
  a_rpl_next:
    assert property (s_scan |=> reset_priority_latch_q
      == (($past(rpl_set) | $past(reset_priority_latch_q)) & ~$past(rpl_reset))) else $error("rpl mismatch");
  a_spl_next:
    assert property (s_scan |=> set_priority_latch_q
      == ($past(spl_set) | ($past(set_priority_latch_q) & ~$past(spl_reset)))) else $error("spl mismatch");
  a_edge_eval:
    assert property (s_scan |=> edge_pulse_q == ($past(edge_result_in) & ~$past(edge_memory_q))
      && edge_memory_q == $past(edge_result_in)) else $error("edge mismatch");
  a_edge_once:
    assert property (s_rise ##1 s_again |=> !edge_pulse_q[0]) else $error("edge pulse repeated");
endmodule : lblp_chk

bind lblp_primitives lblp_chk u_chk (.*);
`default_nettype wire

// file: verif/testbench.sv
// Directed self-checking testbench for the ladder primitive block.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic                          core_clk, reset_n, scan_en, move_en, widen_en;
  logic                          move_enable_passthrough_out_q, widen_enable_passthrough_out_q;
  logic [7:0]                    coil_result_in, coil_out_q, inv_result_in, inv_result_q;
  logic [7:0]                    conn_result_in, conn_store_q, conn_pass_q;
  lblp_pkg::lblp_move_width_type move_width;
  logic [31:0]                   move_src, move_dst_q, widen_out_q;
  logic [15:0]                   widen_in;
  logic [3:0]                    rpl_set, rpl_reset, reset_priority_latch_q;
  logic [3:0]                    spl_set, spl_reset, set_priority_latch_q;
  logic [3:0]                    edge_result_in, edge_pulse_q, edge_memory_q;
  int                            fail_count;
  int                            tests_run;

  lblp_primitives u_dut (.*);

  // Free-running 100 MHz clock
  initial
  begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : check

  // Raise the strobe at an edge; data set right after lands with it
  task arm;
    @(posedge core_clk);
    scan_en <= 1'h1;
  endtask : arm

  // Take the scan, drop the strobe, let outputs settle
  task go;
    @(posedge core_clk);
    scan_en <= 1'h0;
    #1;
  endtask : go

  task stop_test;
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_bits;
    arm;
    coil_result_in <= 8'hA5;
    inv_result_in  <= 8'hA5;
    conn_result_in <= 8'h3C;
    go;
    check("coil", 32'hA5, coil_out_q);
    check("inv", 32'h5A, inv_result_q);
    check("conn", 32'h3C3C, {conn_store_q, conn_pass_q});
    // Inputs moved with no scan must not reach the coils
    @(posedge core_clk);
    coil_result_in <= 8'h0F;
    repeat (2) @(posedge core_clk);
    #1;
    check("coil idle", 32'hA5, coil_out_q);
  endtask : t_bits

  task t_move;
    lblp_pkg::lblp_move_width_type w [3];
    logic [31:0]                   m [3];
    w = '{lblp_pkg::LBLP_MOVE_W8, lblp_pkg::LBLP_MOVE_W16, lblp_pkg::LBLP_MOVE_W32};
    m = '{32'h0000_00FF, 32'h0000_FFFF, 32'hFFFF_FFFF};
    for (int i = 0; i < 3; i++)
    begin
      arm;
      move_en    <= 1'h1;
      move_width <= w[i];
      move_src   <= 32'h8765_4321;
      go;
      check("move", 32'h8765_4321 & m[i], move_dst_q);
      check("move pass", 32'h1, move_enable_passthrough_out_q);
    end
    arm;
    move_en  <= 1'h0;
    move_src <= 32'h0;
    go;
    check("move hold", 32'h8765_4321, move_dst_q);
  endtask : t_move

  task t_widen(input logic en, input logic [15:0] v, input logic [31:0] exp);
    arm;
    widen_en <= en;
    widen_in <= v;
    go;
    check("widen", exp, widen_out_q);
    check("widen pass", {31'h0, en}, widen_enable_passthrough_out_q);
  endtask : t_widen

  // Same set and reset on both latch kinds, lanes differ
  task t_latch(input logic [3:0] s, input logic [3:0] r, input logic [3:0] er, input logic [3:0] es);
    arm;
    {rpl_set, spl_set}     <= {s, s};
    {rpl_reset, spl_reset} <= {r, r};
    go;
    check("rpl", {28'h0, er}, reset_priority_latch_q);
    check("spl", {28'h0, es}, set_priority_latch_q);
  endtask : t_latch

  task t_edge;
    arm;
    edge_result_in <= 4'h5;
    @(posedge core_clk);
    #1;
    check("edge rise", 32'h55, {edge_pulse_q, edge_memory_q});
    go;
    check("edge again", 32'h05, {edge_pulse_q, edge_memory_q});
    arm;
    edge_result_in <= 4'hA;
    go;
    check("edge swap", 32'hAA, {edge_pulse_q, edge_memory_q});
  endtask : t_edge

  // Main sequence: reset, scenarios, verdict
  initial
  begin
    {fail_count, tests_run, reset_n, scan_en, move_en, widen_en} = '0;
    {coil_result_in, inv_result_in, conn_result_in, move_src, widen_in} = '0;
    {rpl_set, rpl_reset, spl_set, spl_reset, edge_result_in} = '0;
    move_width = lblp_pkg::LBLP_MOVE_W8;
    repeat (16) @(posedge core_clk);
    #1;
    check("reset", 32'h0, {coil_out_q, inv_result_q, conn_store_q, conn_pass_q});
    check("reset", 32'h0, move_dst_q | widen_out_q);
    check("reset", 32'h0, {reset_priority_latch_q, set_priority_latch_q, edge_pulse_q, edge_memory_q});
    @(posedge core_clk);
    reset_n <= 1'h1;
    t_bits;
    t_move;
    t_widen(1'h1, 16'h8001, 32'hFFFF_8001);
    t_widen(1'h1, 16'h7FFF, 32'h0000_7FFF);
    t_widen(1'h0, 16'hFFFF, 32'h0000_7FFF);
    t_latch(4'hF, 4'h0, 4'hF, 4'hF);
    t_latch(4'h3, 4'h5, 4'hA, 4'hB);
    t_latch(4'h0, 4'h0, 4'hA, 4'hB);
    t_edge;
    stop_test;
  end
endmodule : testbench
`default_nettype wire
